/* rtl/residual_fault_classifier.sv */
`timescale 1ns/1ps
module residual_fault_classifier
    import fault_class_pkg::*;
#(
    // Least window length in cycles; a shorter setting on the port is
    // raised to it. Lowering it only makes sense to shorten a bench run.
    parameter logic [23:0] MIN_WIN_CYC = MIN_WINDOW_CYC
)
(
    input  wire logic        core_clk_in,
    input  wire logic        reset_n_in,
    input  wire logic        clk_en_in,
    input  wire logic        sample_valid_in,
    input  wire logic [9:0]  sample_in,
    input  wire logic [9:0]  dc_thresh_in,
    input  wire logic [9:0]  ac_thresh_in,
    input  wire logic [9:0]  hyst_level_in,
    input  wire logic [9:0]  zero_near_in,
    input  wire logic [23:0] window_cyc_in,
    output logic             trip_out,
    output logic             fault_ac_out,
    output logic             fault_dc_out,
    output logic             monitoring_out,
    output logic [9:0]       win_max_out,
    output logic [9:0]       win_min_out
);

////////////////////////////////////////////////////////////////////////////////

    class_state_t state;
    class_state_t next_state;
    logic [23:0]  win_count;
    logic [23:0]  next_win_count;
    logic [9:0]   next_max;
    logic [9:0]   next_min;

    wire logic [9:0]  trigger_level;
    wire logic [23:0] window_len;
    wire logic        take;
    wire logic        trigger_hit;
    wire logic        window_done;
    wire logic [9:0]  final_max;
    wire logic [9:0]  final_min;
    wire logic        dc_fault;
    wire logic        ac_fault;
    wire logic        below_hyst;

    assign trigger_level = min10(dc_thresh_in, ac_thresh_in);
    // A window shorter than one zero of the rectified wave would misread AC
    // as DC, so short settings are raised to the least legal length.
    assign window_len    = (window_cyc_in < MIN_WIN_CYC) ?
                           MIN_WIN_CYC : window_cyc_in;
    assign take          = clk_en_in & sample_valid_in;
    assign trigger_hit   = take & (sample_in > trigger_level);
    assign window_done   = (state == ST_MONITOR) &&
                           (win_count >= window_len);
    assign final_max     = (state == ST_MONITOR && take) ?
                           max10(win_max_out, sample_in) : win_max_out;
    assign final_min     = (state == ST_MONITOR && take) ?
                           min10(win_min_out, sample_in) : win_min_out;
    assign dc_fault      = final_min > dc_thresh_in;
    assign ac_fault      = (final_min <= zero_near_in) &&
                           (final_max > ac_thresh_in);
    assign below_hyst    = take & (sample_in < hyst_level_in);

////////////////////////////////////////////////////////////////////////////////

    always_comb begin
        next_state     = state;
        next_win_count = win_count;
        next_max       = win_max_out;
        next_min       = win_min_out;
        case (state)
            ST_SAMPLE: begin
                if (trigger_hit) begin
                    next_state     = ST_MONITOR;
                    next_win_count = COUNT_ONE;
                    next_max       = sample_in;
                    next_min       = sample_in;
                end
            end
            ST_MONITOR: begin
                next_win_count = win_count + COUNT_ONE;
                next_max       = final_max;
                next_min       = final_min;
                if (window_done) begin
                    next_win_count = COUNT_ZERO;
                    if (dc_fault || ac_fault) begin
                        next_state = ST_TRIPPED;
                    end else begin
                        next_state = ST_SAMPLE;
                    end
                end
            end
            ST_TRIPPED: begin
                if (below_hyst) begin
                    next_state = ST_SAMPLE;
                end
            end
            default: begin
                next_state = ST_SAMPLE;
            end
        endcase
    end

////////////////////////////////////////////////////////////////////////////////

    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            state       <= ST_SAMPLE;
            win_count   <= COUNT_ZERO;
            win_max_out <= SAMPLE_ZERO;
            win_min_out <= SAMPLE_MAX;
        end else if (clk_en_in) begin
            state       <= next_state;
            win_count   <= next_win_count;
            win_max_out <= next_max;
            win_min_out <= next_min;
        end
    end

    // Fault type is held until the next classified fault, so software can
    // read the cause after the relay has been released.
    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            fault_dc_out <= 1'b0;
            fault_ac_out <= 1'b0;
        end else if (clk_en_in && window_done &&
                     (dc_fault || ac_fault)) begin
            fault_dc_out <= dc_fault;
            fault_ac_out <= ac_fault & ~dc_fault;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            trip_out       <= 1'b0;
            monitoring_out <= 1'b0;
        end else if (clk_en_in) begin
            trip_out       <= (next_state == ST_TRIPPED);
            monitoring_out <= (next_state == ST_MONITOR);
        end
    end

////////////////////////////////////////////////////////////////////////////////

    sequence trig_s;
        state == ST_SAMPLE && trigger_hit;
    endsequence

    sequence fault_end_s;
        window_done && clk_en_in && (dc_fault || ac_fault);
    endsequence

    trip_on_fault_a: assert property (@(posedge core_clk_in)
        disable iff (!reset_n_in) fault_end_s |=> trip_out)
        else $error("trip not raised after fault");

    enter_monitor_a: assert property (@(posedge core_clk_in)
        disable iff (!reset_n_in) trig_s |=> monitoring_out)
        else $error("monitor not entered on trigger");

    window_length_a: assert property (@(posedge core_clk_in)
        disable iff (!reset_n_in)
        window_done |-> win_count >= MIN_WIN_CYC)
        else $error("window ended too early");

    minmax_hold_a: assert property (@(posedge core_clk_in)
        disable iff (!reset_n_in) state == ST_TRIPPED |=>
        $stable(win_max_out) && $stable(win_min_out))
        else $error("extremes changed outside window");

    dc_class_a: assert property (@(posedge core_clk_in)
        disable iff (!reset_n_in)
        fault_end_s and dc_fault |=> fault_dc_out && !fault_ac_out)
        else $error("dc fault not latched");

    ac_class_a: assert property (@(posedge core_clk_in)
        disable iff (!reset_n_in)
        fault_end_s and !dc_fault |=> fault_ac_out && !fault_dc_out)
        else $error("ac fault not latched");

    trip_release_a: assert property (@(posedge core_clk_in)
        disable iff (!reset_n_in)
        $fell(trip_out) |-> $past(below_hyst))
        else $error("trip released above hysteresis");

    no_fault_a: assert property (@(posedge core_clk_in)
        disable iff (!reset_n_in)
        window_done && clk_en_in && !dc_fault && !ac_fault
        |=> !trip_out && !monitoring_out)
        else $error("no-fault window did not return");

    trigger_low_a: assert property (@(posedge core_clk_in)
        disable iff (!reset_n_in)
        trigger_level <= dc_thresh_in && trigger_level <= ac_thresh_in)
        else $error("trigger level not the lower threshold");

////////////////////////////////////////////////////////////////////////////////

    // The checks below pin down the step-by-step behaviour of the window
    // and of the relay output, so that a change to the next-state logic
    // cannot slip past the end-to-end checks above.

    sequence window_open_s;
        state == ST_MONITOR && clk_en_in && !window_done;
    endsequence

    sequence release_s;
        state == ST_TRIPPED && below_hyst;
    endsequence

    sequence idle_s;
        state == ST_SAMPLE && clk_en_in && !trigger_hit;
    endsequence

    reset_values_a: assert property (@(posedge core_clk_in)
        !reset_n_in |=> !trip_out && !monitoring_out && !fault_ac_out &&
        !fault_dc_out && win_min_out == SAMPLE_MAX)
        else $error("outputs not cleared by reset");

    freeze_hold_a: assert property (@(posedge core_clk_in)
        disable iff (!reset_n_in)
        !clk_en_in |=> $stable(trip_out) && $stable(monitoring_out) &&
        $stable(win_max_out) && $stable(win_min_out))
        else $error("state moved while clock enable low");

    idle_quiet_a: assert property (@(posedge core_clk_in)
        disable iff (!reset_n_in)
        idle_s |=> !monitoring_out && !trip_out)
        else $error("left idle without a trigger");

    idle_hold_a: assert property (@(posedge core_clk_in)
        disable iff (!reset_n_in)
        idle_s |=> $stable(win_max_out) && $stable(win_min_out))
        else $error("extremes changed while idle");

    count_start_a: assert property (@(posedge core_clk_in)
        disable iff (!reset_n_in)
        trig_s |=> win_count == COUNT_ONE &&
        win_max_out == $past(sample_in) &&
        win_min_out == $past(sample_in))
        else $error("window not opened on trigger sample");

    count_step_a: assert property (@(posedge core_clk_in)
        disable iff (!reset_n_in)
        window_open_s |=> win_count == $past(win_count) + COUNT_ONE)
        else $error("window count did not advance");

    no_retrigger_a: assert property (@(posedge core_clk_in)
        disable iff (!reset_n_in)
        window_open_s |=> monitoring_out)
        else $error("window closed before its length");

    extremes_track_a: assert property (@(posedge core_clk_in)
        disable iff (!reset_n_in)
        state == ST_MONITOR && take |=>
        win_max_out >= $past(sample_in) && win_min_out <= $past(sample_in))
        else $error("sample not folded into extremes");

    minmax_order_a: assert property (@(posedge core_clk_in)
        disable iff (!reset_n_in)
        monitoring_out |-> win_min_out <= win_max_out)
        else $error("window minimum above maximum");

    window_floor_a: assert property (@(posedge core_clk_in)
        disable iff (!reset_n_in)
        state == ST_MONITOR && win_count < MIN_WIN_CYC |-> !window_done)
        else $error("window ended below its floor");

    len_floor_a: assert property (@(posedge core_clk_in)
        disable iff (!reset_n_in)
        window_len >= MIN_WIN_CYC &&
        (window_cyc_in < MIN_WIN_CYC || window_len == window_cyc_in))
        else $error("window length setting not honoured");

    end_closes_a: assert property (@(posedge core_clk_in)
        disable iff (!reset_n_in)
        window_done && clk_en_in |=> !monitoring_out && win_count == COUNT_ZERO)
        else $error("window did not close at its end");

    fault_keep_a: assert property (@(posedge core_clk_in)
        disable iff (!reset_n_in)
        !(window_done && clk_en_in && (dc_fault || ac_fault)) |=>
        $stable(fault_ac_out) && $stable(fault_dc_out))
        else $error("fault type changed without a fault");

    fault_excl_a: assert property (@(posedge core_clk_in)
        disable iff (!reset_n_in) !(fault_ac_out && fault_dc_out))
        else $error("both fault types latched");

    mon_trip_excl_a: assert property (@(posedge core_clk_in)
        disable iff (!reset_n_in) !(monitoring_out && trip_out))
        else $error("tripped while still monitoring");

    trip_hold_a: assert property (@(posedge core_clk_in)
        disable iff (!reset_n_in)
        state == ST_TRIPPED && !below_hyst |=> trip_out)
        else $error("trip dropped above hysteresis");

    release_drop_a: assert property (@(posedge core_clk_in)
        disable iff (!reset_n_in)
        release_s |=> !trip_out && !monitoring_out)
        else $error("trip held below hysteresis");
endmodule

/* rtl/fault_class_pkg.sv */
// Function
// - Trip output goes high whenever an AC or DC fault is classified.
// - Sample continuously; enter monitoring when a sample exceeds trigger level.
// - Monitoring window lasts longer than 10 ms.
// - Recommended window length is 13 ms (REC_WINDOW_CYC); the window_cyc_in port has no default.
// - Track maximum and minimum samples through the window; hold them after.
// - DC fault when window minimum stays above the DC threshold.
// - AC fault when minimum is near zero and maximum exceeds AC threshold.
// - Latch fault type, AC or DC, and raise the trip output on the same clock edge.
// - Trip output drops only once the signal falls below hysteresis level.
// - Trigger level is the lower of the AC and DC thresholds.
package fault_class_pkg;
    localparam int          SAMPLE_W        = 10;
    localparam int          WIN_W           = 24;
    localparam int          CLK_MHZ         = 100;
    localparam int          MIN_WINDOW_MS   = 10;
    localparam int          REC_WINDOW_MS   = 13;
    // Window lengths in cycles; the least must be exceeded, hence the +1.
    localparam logic [23:0] MIN_WINDOW_CYC  =
        24'(MIN_WINDOW_MS * 1000 * CLK_MHZ + 1);
    localparam logic [23:0] REC_WINDOW_CYC  =
        24'(REC_WINDOW_MS * 1000 * CLK_MHZ);
    localparam logic [9:0]  ZERO_NEAR_RST   = 10'h008;
    localparam logic [9:0]  SAMPLE_MAX      = 10'h3ff;
    localparam logic [9:0]  SAMPLE_ZERO     = 10'h000;
    localparam logic [23:0] COUNT_ZERO      = 24'h000000;
    localparam logic [23:0] COUNT_ONE       = 24'h000001;

    typedef enum logic [1:0] {
        ST_SAMPLE,
        ST_MONITOR,
        ST_TRIPPED
    } class_state_t;

    function automatic logic [9:0] min10(input logic [9:0] a,
                                         input logic [9:0] b);
        return (a < b) ? a : b;
    endfunction

    function automatic logic [9:0] max10(input logic [9:0] a,
                                         input logic [9:0] b);
        return (a > b) ? a : b;
    endfunction
endpackage

/* test/sample_source.sv */
`timescale 1ns/1ps
module sample_source (
    input  wire logic       core_clk_in,
    input  wire logic       ac_mode_in,
    input  wire logic [9:0] level_in,
    output logic            sample_valid_out = 1'b0,
    output logic [9:0]      sample_out = 10'h000
);
    logic [1:0] pace = 2'h0;
    logic [4:0] step = 5'h00;
    wire  [9:0] ramp = 10'((level_in / 16) * step);
    // One conversion every four cycles, far above the slowest legal rate.
    always @(posedge core_clk_in) begin
        pace             <= pace + 2'h1;
        sample_valid_out <= (pace == 2'h0);
        if (pace == 2'h0) begin
            step       <= (step == 5'h10) ? 5'h00 : step + 5'h01;
            sample_out <= ac_mode_in ? ramp : level_in;
        end else begin
            // Between conversions the bus must not look like a sample.
            sample_out <= ~sample_out;
        end
    end
endmodule

/* test/residual_fault_classifier_bench.sv */
`timescale 1ns/1ps
module residual_fault_classifier_bench;
    import fault_class_pkg::*;
    logic        core_clk_in = 1'b0;
    logic        reset_n_in  = 1'b0;
    logic        clk_en_in   = 1'b0;
    logic        ac_mode     = 1'b0;
    logic [9:0]  level       = 10'h180;
    logic [23:0] window_cyc  = 24'h000000;
    logic        valid;
    logic [9:0]  sample;
    logic        trip;
    logic        f_ac;
    logic        f_dc;
    logic        mon;
    logic [9:0]  w_max;
    logic [9:0]  w_min;
    int          miscompares = 0;
    int          n_checks    = 0;
    int          n;
    always #5 core_clk_in = ~core_clk_in;
    ////////////////////////////////////////////////////////////////////////
    sample_source src (.core_clk_in(core_clk_in), .ac_mode_in(ac_mode),
        .level_in(level), .sample_valid_out(valid), .sample_out(sample));
    // The window floor is scaled down so that a run stays short.
    residual_fault_classifier #(.MIN_WIN_CYC(24'h0007d1))
        uut (.core_clk_in(core_clk_in),
        .reset_n_in(reset_n_in), .clk_en_in(clk_en_in),
        .sample_valid_in(valid), .sample_in(sample),
        .dc_thresh_in(10'h100), .ac_thresh_in(10'h200),
        .hyst_level_in(10'h080), .zero_near_in(10'h008),
        .window_cyc_in(window_cyc), .trip_out(trip), .fault_ac_out(f_ac),
        .fault_dc_out(f_dc), .monitoring_out(mon), .win_max_out(w_max),
        .win_min_out(w_min));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [9:0] seen, input logic [9:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        if (miscompares == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Measures one window; the wait for its end is bounded past the longest window.
    task automatic run_window();
        n = 0;
        for (int i = 0; i < 2000 && mon !== 1'b1; i++) begin
            @(posedge core_clk_in);
            #1;
        end
        for (int i = 0; i < 10000 && mon === 1'b1; i++) begin
            @(posedge core_clk_in);
            #1;
            n++;
        end
        if (mon !== 1'b0 || n == 0) begin
            miscompares++;
            test_done();
        end
        #1;
    endtask
    task automatic wait_cyc(input int c);
        repeat (c) @(posedge core_clk_in);
        #1;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        wait_cyc(12);
        check(10'(trip), 10'h000);
        check(w_min, 10'h3ff);
        check(w_max, 10'h000);
        reset_n_in <= 1'b1;
        // A frozen block must ignore a sample above the trigger level.
        wait_cyc(20);
        check(10'(mon), 10'h000);
        clk_en_in <= 1'b1;
        run_window();
        check(10'(n >= 2000 && n <= 2002), 10'h001);
        check(10'(trip), 10'h001);
        check(10'(f_dc), 10'h001);
        check(10'(f_ac), 10'h000);
        check(w_max, 10'h180);
        check(w_min, 10'h180);
        level <= 10'h090;
        wait_cyc(50);
        check(10'(trip), 10'h001);
        level <= 10'h040;
        wait_cyc(10);
        check(10'(trip), 10'h000);
        check(10'(f_dc), 10'h001);
        window_cyc <= 24'h000a28;
        ac_mode    <= 1'b1;
        level      <= 10'h280;
        run_window();
        check(10'(n >= 2599 && n <= 2601), 10'h001);
        check(10'(trip), 10'h001);
        check(10'(f_ac), 10'h001);
        check(10'(f_dc), 10'h000);
        check(w_max, 10'h280);
        check(w_min, 10'h000);
        ac_mode <= 1'b0;
        level   <= 10'h000;
        wait_cyc(10);
        check(10'(trip), 10'h000);
        ac_mode <= 1'b1;
        level   <= 10'h180;
        run_window();
        check(10'(trip), 10'h000);
        check(w_max, 10'h180);
        test_done();
    end
endmodule
